// ==== hw/bus_pad_pkg.sv ====
// Constants, field layouts and carrier types of the bus pad configuration bank
package bus_pad_pkg;

  // ==========================================================
  // Sizes
  localparam int          BUS_PINS   = 6;
  localparam int          LVL_PORTS  = 6;
  localparam int          ADDR_W     = 12;
  localparam logic [2:0]  REG_COUNT  = 3'h6;

  // ==========================================================
  // Register map: bank select is paddr[11:5], index paddr[4:2]
  localparam logic [6:0]  BANK_BUS_CTRL  = 7'h00;
  localparam logic [6:0]  BANK_INPUT_LVL = 7'h01;
  localparam logic [11:0] BUS_CTRL_BASE  = 12'h000;
  localparam logic [11:0] INPUT_LVL_BASE = 12'h020;
  localparam logic [2:0]  PORT_E_IDX     = 3'h4;

  // ==========================================================
  // Bus pad control fields
  localparam int          SLEW_BIT     = 6;
  localparam int          BIAS_LSB     = 4;
  localparam int          TRIP_LSB     = 0;
  localparam logic [7:0]  BUS_CTRL_MASK  = 8'h73;
  localparam logic [7:0]  BUS_CTRL_RESET = 8'h00;

  localparam logic [1:0]  BIAS_STD     = 2'h0;
  localparam logic [1:0]  BIAS_2X      = 2'h1;
  localparam logic [1:0]  BIAS_10X     = 2'h2;
  localparam logic [1:0]  TRIP_STD     = 2'h0;
  localparam logic [1:0]  TRIP_BUS     = 2'h1;
  localparam logic [1:0]  TRIP_SMBUS2  = 2'h2;
  localparam logic [1:0]  TRIP_SMBUS3  = 2'h3;

  // ==========================================================
  // Input level registers
  localparam logic [7:0]  LVL_MASK       = 8'hFF;
  localparam logic [7:0]  LVL_MASK_E     = 8'h0F;
  localparam logic [7:0]  LVL_RESET      = 8'hFF;
  localparam logic [7:0]  LVL_RESET_E    = 8'h0F;

  // ==========================================================
  // Bus-capable pins, listed pin 5 down to pin 0: D1 D0 C4 C3 B2 B1
  localparam logic [5:0][2:0] BUS_PIN_PORT = {3'h3, 3'h3, 3'h2, 3'h2, 3'h1, 3'h1};
  localparam logic [5:0][2:0] BUS_PIN_BIT  = {3'h1, 3'h0, 3'h4, 3'h3, 3'h2, 3'h1};

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic hit;
    logic is_bus;
    logic [2:0] idx;
  } addr_hit_t;

  typedef struct packed {
    logic bus_slew_en;
    logic std_slew_limit;
    logic std_pull_en;
    logic pull_2x_en;
    logic pull_10x_en;
    logic thr_smbus3;
    logic thr_smbus2;
    logic thr_bus_specific;
    logic schmitt_input;
    logic thr_ttl;
    logic periph_bus_schmitt;
  } pad_drive_t;

endpackage : bus_pad_pkg

// ==== hw/bus_pad_config_bank.sv ====
// APB register bank that configures the pads of the two-wire bus capable pins
//
// What this block does
// - Bus slew bit overrides standard slew limiting
// - Bus slew clear: general edge-rate bit rules
// - Bias code 10 ten-fold, 01 two-fold; 11 reserved
// - Bias code 00 defers to general pull-up
// - Trip codes select SMBus3, SMBus2, bus thresholds
// - Trip code 00 defers to input-level bit
// - Bits 7, 3, 2 ignore writes, read zero
// - Control fields reset to zero on reset
// - Peripherals get bus Schmitt input when enabled
// - Input-level bit: set Schmitt, clear TTL
// - Weak pull-up bit enables standard pull-up
// - Edge-rate bit limits slew, clear maximum
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module bus_pad_config_bank
  import bus_pad_pkg::*;
(
  input  wire logic                 pclk,                 // APB clock, 10 MHz
  input  wire logic                 presetn,              // Async reset, low
  input  wire logic                 psel,                 // Slave select
  input  wire logic                 penable,              // Access phase
  input  wire logic                 pwrite,               // Write when high
  input  wire logic [ADDR_W-1:0]    paddr,                // Byte address
  input  wire logic [31:0]          pwdata,               // Write data
  input  wire logic [3:0]           pstrb,                // Byte lane strobes
  output var  logic [31:0]          prdata,               // Read data
  output var  logic                 pready,               // Transfer ready
  output var  logic                 pslverr,              // Unmapped access
  input  wire logic [BUS_PINS-1:0]  pin_edge_rate_limit,  // General slew bits
  input  wire logic [BUS_PINS-1:0]  pin_weak_bias_en,     // General pull-up bits
  output var  pad_drive_t [BUS_PINS-1:0] bus_pad_drive,   // Per bus pin pad setup
  output var  logic [LVL_PORTS-1:0][7:0] pin_input_level_sel // Per port level select
);

  // ==========================================================
  // Address decode, shared by the read and the write path
  function automatic addr_hit_t decode_addr(input logic [ADDR_W-1:0] a);
    addr_hit_t r;
    r.hit    = 1'b0;
    r.is_bus = 1'b0;
    r.idx    = a[4:2];
    if (a[1:0] != 2'h0) begin
      r.hit = 1'b0;
    end else if (a[4:2] >= REG_COUNT) begin
      r.hit = 1'b0;
    end else if (a[11:5] == BANK_BUS_CTRL) begin
      r.hit    = 1'b1;
      r.is_bus = 1'b1;
    end else if (a[11:5] == BANK_INPUT_LVL) begin
      r.hit = 1'b1;
    end
    return r;
  endfunction : decode_addr

  // ==========================================================
  // Pad decode of one bus-capable pin
  function automatic pad_drive_t decode_pad(
    input logic [7:0] ctrl,
    input logic       gen_slew,
    input logic       gen_pull,
    input logic       gen_level
  );
    pad_drive_t d;
    logic [1:0] bias;
    logic [1:0] trip;
    bias = ctrl[BIAS_LSB +: 2];
    trip = ctrl[TRIP_LSB +: 2];
    d    = '0;
    if (ctrl[SLEW_BIT]) begin
      d.bus_slew_en    = 1'b1;
      d.std_slew_limit = 1'b0;
    end else begin
      d.std_slew_limit = gen_slew;
    end
    // Reserved bias code falls back to the standard pull-up path
    if (bias == BIAS_10X) begin
      d.pull_10x_en = 1'b1;
    end else if (bias == BIAS_2X) begin
      d.pull_2x_en = 1'b1;
    end else begin
      d.std_pull_en = gen_pull;
    end
    case (trip)
      TRIP_SMBUS3: d.thr_smbus3 = 1'b1;
      TRIP_SMBUS2: d.thr_smbus2 = 1'b1;
      TRIP_BUS: begin
        d.thr_bus_specific   = 1'b1;
        d.periph_bus_schmitt = 1'b1;
      end
      default: begin
        d.schmitt_input = gen_level;
        d.thr_ttl       = ~gen_level;
      end
    endcase
    return d;
  endfunction : decode_pad

  // ==========================================================
  // One-hot register select, shared by both write banks
  function automatic logic [BUS_PINS-1:0] idx_onehot(input logic [2:0] idx);
    logic [BUS_PINS-1:0] v;
    for (int k = 0; k < BUS_PINS; k++) begin
      v[k] = (idx == k[2:0]);
    end
    return v;
  endfunction : idx_onehot

  // ==========================================================
  // Implemented bits of one input level register; port E is short
  function automatic logic [7:0] lvl_mask_of(input logic [2:0] idx);
    logic [7:0] m;
    m = LVL_MASK;
    if (idx == PORT_E_IDX) begin
      m = LVL_MASK_E;
    end
    return m;
  endfunction : lvl_mask_of

  // Reset value of one input level register, shared by the stored copy
  // and the output copy so the two can never disagree after reset
  function automatic logic [7:0] lvl_reset_of(input logic [2:0] idx);
    logic [7:0] v;
    v = LVL_RESET;
    if (idx == PORT_E_IDX) begin
      v = LVL_RESET_E;
    end
    return v;
  endfunction : lvl_reset_of

  // ==========================================================
  // Read multiplexer: a refused address reads as zero
  function automatic logic [31:0] read_word(
    input addr_hit_t  s,
    input logic [7:0] bus_val,
    input logic [7:0] lvl_val
  );
    logic [31:0] w;
    w = '0;
    if (s.hit && s.is_bus) begin
      w[7:0] = bus_val;
    end else if (s.hit) begin
      w[7:0] = lvl_val;
    end
    return w;
  endfunction : read_word

  // ==========================================================
  // Register storage and next values
  logic [7:0]  bus_ctrl_reg  [BUS_PINS];
  logic [7:0]  bus_ctrl_next [BUS_PINS];
  logic [7:0]  lvl_reg       [LVL_PORTS];
  logic [7:0]  lvl_next      [LVL_PORTS];
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  addr_hit_t   sel;
  logic        setup_phase;
  logic        wr_take;
  logic [BUS_PINS-1:0]  bus_wr_sel;
  logic [LVL_PORTS-1:0] lvl_wr_sel;
  pad_drive_t [BUS_PINS-1:0] drive_next;

  assign sel         = decode_addr(paddr);
  assign setup_phase = psel & ~penable;
  // Write lands only at the edge where the access phase sees pready
  assign wr_take     = psel & penable & pwrite & pready_reg & pstrb[0];
  // A refused address never reaches either bank
  assign bus_wr_sel  = (wr_take && sel.hit && sel.is_bus) ? idx_onehot(sel.idx) : '0;
  assign lvl_wr_sel  = (wr_take && sel.hit && !sel.is_bus) ? idx_onehot(sel.idx) : '0;

  // ==========================================================
  // Write path: reserved bits are masked off before they are stored
  always_comb begin
    for (int i = 0; i < BUS_PINS; i++) begin
      bus_ctrl_next[i] = bus_ctrl_reg[i];
      if (bus_wr_sel[i]) begin
        bus_ctrl_next[i] = pwdata[7:0] & BUS_CTRL_MASK;
      end
    end
  end

  always_comb begin
    for (int p = 0; p < LVL_PORTS; p++) begin
      lvl_next[p] = lvl_reg[p];
      if (lvl_wr_sel[p]) begin
        lvl_next[p] = pwdata[7:0] & lvl_mask_of(p[2:0]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < BUS_PINS; i++) begin
        bus_ctrl_reg[i] <= BUS_CTRL_RESET;
      end
    end else begin
      for (int i = 0; i < BUS_PINS; i++) begin
        bus_ctrl_reg[i] <= bus_ctrl_next[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < LVL_PORTS; p++) begin
        lvl_reg[p] <= lvl_reset_of(p[2:0]);
      end
    end else begin
      for (int p = 0; p < LVL_PORTS; p++) begin
        lvl_reg[p] <= lvl_next[p];
      end
    end
  end

  // ==========================================================
  // APB answer: one cycle after setup, so zero wait states in access
  always_comb begin
    pready_next  = setup_phase;
    pslverr_next = setup_phase & ~sel.hit;
    prdata_next  = prdata_reg;
    if (setup_phase) begin
      prdata_next = '0;
      if (!pwrite) begin
        prdata_next = read_word(sel, bus_ctrl_reg[sel.idx], lvl_reg[sel.idx]);
      end
    end
  end

  // Ready and error are one-cycle pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= pready_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= pslverr_next;
    end
  end

  // Read data holds until the next setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata  = prdata_reg;

  // ==========================================================
  // Pad outputs: decoded from next values so the flops change at the
  // write edge itself; the general per-pin inputs see one flop of delay
  for (genvar g = 0; g < BUS_PINS; g++) begin : g_pad
    assign drive_next[g] = decode_pad(
      bus_ctrl_next[g],
      pin_edge_rate_limit[g],
      pin_weak_bias_en[g],
      lvl_next[BUS_PIN_PORT[g]][BUS_PIN_BIT[g]]
    );
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_pad_drive <= '0;
    end else begin
      bus_pad_drive <= drive_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < LVL_PORTS; p++) begin
        pin_input_level_sel[p] <= lvl_reset_of(p[2:0]);
      end
    end else begin
      for (int p = 0; p < LVL_PORTS; p++) begin
        pin_input_level_sel[p] <= lvl_next[p];
      end
    end
  end

endmodule : bus_pad_config_bank

`default_nettype wire

// ==== tb/bus_pad_config_bank_assertions.sv ====
// Port checker for the bus pad configuration bank
`timescale 1ns/1ps
`default_nettype none
module bus_pad_checker
  import bus_pad_pkg::*;
(
  input wire logic                      pclk,                // Clock
  input wire logic                      presetn,             // Reset, low
  input wire logic                      psel,                // Select
  input wire logic                      penable,             // Access
  input wire logic                      pwrite,              // Write
  input wire logic [ADDR_W-1:0]         paddr,               // Address
  input wire logic [31:0]               pwdata,              // Write data
  input wire logic [3:0]                pstrb,               // Strobes
  input wire logic [31:0]               prdata,              // Read data
  input wire logic                      pready,              // Ready
  input wire logic                      pslverr,             // Error
  input wire logic [BUS_PINS-1:0]       pin_edge_rate_limit, // Slew bits
  input wire logic [BUS_PINS-1:0]       pin_weak_bias_en,    // Pull bits
  input wire pad_drive_t [BUS_PINS-1:0] bus_pad_drive,       // Pads
  input wire logic [LVL_PORTS-1:0][7:0] pin_input_level_sel  // Levels
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic up_reg;
  // Pads still show reset values at the first edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_reg <= 1'b0;
    else up_reg <= 1'b1;
  end
  // ======
  // Bus side
  setup_ready_a: assert property (
    psel && !penable |=> pready) else $error("no ready after setup");
  ready_pulse_a: assert property (
    pready |=> !pready) else $error("ready held");
  ctrl_read_a: assert property (
    pready && !pwrite && !pslverr && paddr[11:5] == 7'h00 |-> (prdata & 32'hFFFFFF8C) == 32'h0)
    else $error("reserved bits read");
  wr_apply_a: assert property (
    psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h000
    |=> bus_pad_drive[0].bus_slew_en == $past(pwdata[6])) else $error("write not applied");
  // ======
  // Pad side
  for (genvar i = 0; i < BUS_PINS; i++) begin : g_pin
    pad_drive_t d;
    assign d = bus_pad_drive[i];
    slew_mode_a: assert property (
      up_reg |-> d.std_slew_limit == (!d.bus_slew_en && $past(pin_edge_rate_limit[i])))
      else $error("slew mode wrong");
    bias_excl_a: assert property (
      $onehot0({d.std_pull_en, d.pull_2x_en, d.pull_10x_en})) else $error("pull clash");
    pull_std_a: assert property (
      up_reg && !d.pull_2x_en && !d.pull_10x_en |-> d.std_pull_en == $past(pin_weak_bias_en[i]))
      else $error("standard pull wrong");
    trip_one_a: assert property (
      up_reg |-> $onehot({d.thr_smbus3, d.thr_smbus2, d.thr_bus_specific, d.schmitt_input,
      d.thr_ttl})) else $error("threshold not unique");
    level_use_a: assert property (
      d.schmitt_input || d.thr_ttl |-> d.schmitt_input ==
      pin_input_level_sel[BUS_PIN_PORT[i]][BUS_PIN_BIT[i]]) else $error("level bit ignored");
    periph_st_a: assert property (
      d.periph_bus_schmitt == d.thr_bus_specific) else $error("peripheral input wrong");
  end
  cover property (psel && penable && pready && pwrite);
  cover property (pready && pslverr);
  cover property (bus_pad_drive[0].bus_slew_en);
endmodule : bus_pad_checker
`default_nettype wire

// ==== tb/test_bus_pad_config_bank.sv ====
// Self-checking bench for the bus pad configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_bus_pad_config_bank import bus_pad_pkg::*;;
  logic                      pclk = 1'b0, presetn = 1'b0;
  logic                      psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0]         paddr = '0;
  logic [31:0]               pwdata = '0, prdata, rd;
  logic [3:0]                pstrb = 4'hF;
  logic                      pready, pslverr, er;
  logic [BUS_PINS-1:0]       slew_in = '0, pull_in = '0;
  pad_drive_t [BUS_PINS-1:0] pads;
  logic [LVL_PORTS-1:0][7:0] lvl;
  int                        num_errors = 0, num_checks = 0;
  always #50 pclk = ~pclk;
  bus_pad_config_bank dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .pin_edge_rate_limit(slew_in), .pin_weak_bias_en(pull_in),
    .bus_pad_drive(pads), .pin_input_level_sel(lvl));
  // ======
  // Shared tasks
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(logic w, logic [11:0] a, logic [7:0] d, logic [3:0] s);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      give_verdict();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  function automatic pad_drive_t pad_exp(logic [7:0] c, logic gs, logic gp, logic lv);
    logic [1:0] b = c[5:4];
    logic [1:0] t = c[1:0];
    return {c[6], !c[6] && gs, (b == 2'h0 || b == 2'h3) && gp, b == 2'h1, b == 2'h2,
            t == 2'h3, t == 2'h2, t == 2'h1, t == 2'h0 && lv, t == 2'h0 && !lv, t == 2'h1};
  endfunction : pad_exp
  // ======
  // Scenarios
  task automatic reset_values();
    for (int k = 0; k < 12; k++) begin
      apb(1'b0, 12'(k % 6 * 4 + k / 6 * 32), 8'h00, 4'h1);
      check("reset value", rd, k < 6 ? 32'h0 : (k == 10 ? 32'h0F : 32'hFF));
    end
  endtask : reset_values
  task automatic ctrl_codes();
    logic [3:0] q;
    logic [7:0] v;
    int p;
    for (int k = 0; k < 16; k++) begin
      q = 4'(k);
      p = k % 6;
      // Reserved bits set on purpose: they must be dropped
      v = {1'b1, q[3], q[1:0], 2'h3, q[3:2]};
      @(posedge pclk);
      slew_in <= {6{q[0]}};
      pull_in <= {6{q[2]}};
      apb(1'b1, 12'(p * 4), v, 4'h1);
      apb(1'b0, 12'(p * 4), 8'h00, 4'h1);
      check("ctrl read", rd, {24'h0, v & 8'h73});
      @(negedge pclk);
      check("pad drive", 32'(pads[p]), 32'(pad_exp(v, q[0], q[2], 1'b1)));
    end
  endtask : ctrl_codes
  task automatic level_sel();
    apb(1'b1, 12'h028, 8'hE7, 4'h1);
    apb(1'b1, 12'h030, 8'hFF, 4'h1);
    apb(1'b1, 12'h008, 8'h00, 4'h1);
    apb(1'b0, 12'h030, 8'h00, 4'h1);
    check("port e", rd, 32'h0F);
    @(negedge pclk);
    check("level out", {lvl[4], lvl[2]}, 32'h0FE7);
    check("ttl pad", 32'(pads[2]), 32'(pad_exp(8'h00, slew_in[2], pull_in[2], 1'b0)));
  endtask : level_sel
  task automatic refusals();
    apb(1'b1, 12'h014, 8'h12, 4'h1);
    apb(1'b1, 12'h014, 8'h40, 4'h0);
    apb(1'b1, 12'h018, 8'h40, 4'h1);
    check("unmapped err", er, 1'b1);
    apb(1'b1, 12'h054, 8'h40, 4'h1);
    check("bank err", er, 1'b1);
    apb(1'b0, 12'h018, 8'h00, 4'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b0, 12'h015, 8'h00, 4'h1);
    check("misaligned err", er, 1'b1);
    check("misaligned data", rd, 32'h0);
    apb(1'b0, 12'h014, 8'h00, 4'h1);
    check("strobe off", rd, 32'h12);
    check("mapped err", er, 1'b0);
  endtask : refusals
  task automatic mid_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    check("reset pad", 32'(pads[5]), 32'(pad_exp(8'h00, slew_in[5], pull_in[5], 1'b1)));
    check("reset levels", {lvl[4], lvl[2]}, 32'h0FFF);
    reset_values();
  endtask : mid_reset
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    reset_values();
    ctrl_codes();
    level_sel();
    refusals();
    mid_reset();
    give_verdict();
  end
endmodule : test_bus_pad_config_bank
bind bus_pad_config_bank bus_pad_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pin_edge_rate_limit,
  .pin_weak_bias_en, .bus_pad_drive, .pin_input_level_sel);
`default_nettype wire
